// file: common/lbi_defs.svh
// Constants for the local bus master: size codes, port codes, strap fields.
// Included by the design, the checker and the bench, each also importing lbi_pkg.
// Overview of operation
// RL1 - Full 32-bit address is driven on the bus during the first clock.
// RL2 - Data phase uses the byte lanes of the matched select's port size.
// RL3 - A select asserts only when the address falls in its base/mask region.
// RL4 - Each select has base, mask, port size, burst, wait count, termination.
// RL5 - Reset clears selects; select zero alone works, decoding every address.
// RL6 - Boot port size and termination come from low bus lines at reset rise.
// RL7 - Start strobe lasts one clock with address and attributes valid.
// RL8 - Direction is high for reads and low for writes.
// RL9 - Burst indicator is active through bursts of 2 to 16 beats.
// RL10 - Size code: 00 four bytes, 01 byte, 10 two bytes, 11 line.
// RL11 - Byte, word, longword operands to 8, 16 and 32-bit ports.
// RL12 - Misaligned operands split into aligned pieces, each showing its size.
// RL13 - Aligned burst wider than port shows full size for whole burst.
// RL14 - Unbursted wide transfer shows full size first, then port size.
// RL15 - Per select, byte strobes on reads and writes, or writes only.
// RL16 - Only byte strobes for lanes actually used are asserted.
// RL17 - Output enable asserts on reads, only with a matched select.
// RL18 - Write data stays driven one clock after the select negates.
// RL19 - Peripheral holds read data until the acknowledge is recognised.
// RL20 - Externally terminated cycles end only on the peripheral acknowledge.
// RL21 - Wait states come from the internal count or external acknowledge.
// RL22 - Internal termination ends the cycle after the programmed wait count.
`ifndef LBI_DEFS_SVH
`define LBI_DEFS_SVH

`define LBI_NUM_CS     6
`define LBI_TSZ_LONG   2'h0
`define LBI_TSZ_BYTE   2'h1
`define LBI_TSZ_WORD   2'h2
`define LBI_TSZ_LINE   2'h3
`define LBI_PS_32      2'h0
`define LBI_PS_8       2'h1
`define LBI_PS_16      2'h2
`define LBI_STRAP_AA   2
`define LBI_BOOT_WAIT  6'h3f
`define LBI_LANES_OFF  4'hf
`define LBI_CS_OFF     6'h3f

`endif

// file: common/lbi_pkg.sv
// Types for the local bus master.
// Assumes compilation before the design module.
package lbi_pkg;
   typedef enum logic [1:0] {LBI_IDLE, LBI_ADDR, LBI_DATA, LBI_HOLD} lbi_state_t;
endpackage

// file: hw/lbi_master.sv
// Local bus master: six chip selects, multiplexed address/data, split and
// burst transfers, internal or external termination.
// Assumes pins arrive asynchronously and user/config ports share mclk.
`timescale 1ns/1ps
`default_nettype none
`include "lbi_defs.svh"

module lbi_master
   import lbi_pkg::*;
(
   input  wire logic         mclk,           // 40 MHz clock
   input  wire logic         srst,           // Sync reset, active high
   input  wire logic         cfg_we,         // Write one select's settings
   input  wire logic [2:0]   cfg_idx,        // Select index 0..5
   input  wire logic         cfg_valid,      // Select enabled
   input  wire logic [15:0]  cfg_base,       // Base, address bits 31:16
   input  wire logic [15:0]  cfg_mask,       // Set bits ignored in compare
   input  wire logic [1:0]   cfg_psize,      // Port size code
   input  wire logic         cfg_burst,      // Port accepts bursts
   input  wire logic [5:0]   cfg_wait,       // Auto-ack wait states
   input  wire logic         cfg_auto_ack,   // 1 internal, 0 external end
   input  wire logic         cfg_read_lanes, // Byte strobes on reads too
   input  wire logic         req_valid,      // Transfer request
   output logic              req_ready,      // Engine idle
   input  wire logic         req_read,       // 1 read, 0 write
   input  wire logic [1:0]   req_size,       // Operand size code
   input  wire logic         req_burst_ok,   // Bursting allowed
   input  wire logic [31:0]  req_addr,       // Byte address
   input  wire logic [127:0] req_wdata,      // Write bytes, first at top
   output logic              done,           // Transfer finished pulse
   output logic              no_match,       // No select matched pulse
   output logic [127:0]      rdata,          // Read bytes, first at top
   input  wire logic [31:0]  ad_in,          // Bus lines as seen on pins
   output logic [31:0]       ad_out,         // Bus lines driven value
   output logic              ad_oe_n,        // Low while driving bus
   output logic [5:0]        chip_select_n,  // Chip selects
   output logic              cycle_begin_n,  // Transfer start strobe
   output logic              read_write,     // Direction
   output logic              burst_flag_n,   // Burst in progress
   output logic [1:0]        transfer_size,  // Size of access
   output logic [3:0]        lane_select_n,  // Byte strobes
   output logic              output_en_n,    // Read output enable
   input  wire logic         cycle_ack_n,    // External acknowledge
   input  wire logic         reset_in_n      // Board reset pin
);

   // Select settings
   logic [15:0]  cs_base_r  [`LBI_NUM_CS];
   logic [15:0]  cs_mask_r  [`LBI_NUM_CS];
   logic [1:0]   cs_psize_r [`LBI_NUM_CS];
   logic [5:0]   cs_wait_r  [`LBI_NUM_CS];
   logic [5:0]   cs_valid_r;
   logic [5:0]   cs_burst_r;
   logic [5:0]   cs_aa_r;
   logic [5:0]   cs_rdl_r;
   logic         global_r;

   // Synchronisers
   logic [31:0]  ad_s1_r, ad_s2_r;
   logic         ack_s1_r, ack_s2_r;
   logic         rst_s1_r, rst_s2_r, rst_s3_r;

   // Transfer state
   lbi_state_t   st_r;
   logic [31:0]  cur_r;
   logic [4:0]   rem_r;
   logic [4:0]   cnt_r;
   logic [1:0]   size_r;
   logic         read_r;
   logic         burst_r;
   logic         first_r;
   logic         aligned_r;
   logic [2:0]   sel_r;
   logic [2:0]   n_r;
   logic [5:0]   wait_r;
   logic [127:0] wbuf_r;
   logic [127:0] rbuf_r;

   // Combinational helpers
   logic [5:0]   match;
   logic [2:0]   hit_idx;
   logic         hit;
   logic [2:0]   pb;
   logic [2:0]   n_nxt;
   logic [1:0]   off;
   logic [1:0]   tsiz_nxt;
   logic [3:0]   lanes_nxt;
   logic [31:0]  wlane_nxt;
   logic         ack;
   logic [4:0]   req_bytes;
   logic [4:0]   req_pb;
   logic         req_aligned;

   function automatic logic [2:0] port_bytes(input logic [1:0] ps);
      port_bytes = (ps == `LBI_PS_8) ? 3'd1 : (ps == `LBI_PS_32) ? 3'd4 : 3'd2;
   endfunction

   function automatic logic [4:0] size_bytes(input logic [1:0] sz);
      unique case (sz)
         `LBI_TSZ_LONG: size_bytes = 5'd4;
         `LBI_TSZ_BYTE: size_bytes = 5'd1;
         `LBI_TSZ_WORD: size_bytes = 5'd2;
         `LBI_TSZ_LINE: size_bytes = 5'd16;
      endcase
   endfunction

   // Two-flop synchronisers for all pin inputs
   always_ff @(posedge mclk)
   begin
      ad_s1_r  <= ad_in;
      ad_s2_r  <= ad_s1_r;
      ack_s1_r <= cycle_ack_n;
      ack_s2_r <= ack_s1_r;
      rst_s1_r <= reset_in_n;
      rst_s2_r <= rst_s1_r;
      rst_s3_r <= rst_s2_r;
   end

   // Address decode, lowest matching select wins
   genvar gi;
   generate
      for (gi = 0; gi < `LBI_NUM_CS; gi++)
      begin : g_dec
         if (gi == 0)
         begin : g_boot
            assign match[gi] = cs_valid_r[gi] & (global_r |
               (((req_addr[31:16] ^ cs_base_r[gi]) & ~cs_mask_r[gi]) == 16'h0000)); // RL3 RL5
         end
         else
         begin : g_norm
            assign match[gi] = cs_valid_r[gi] &
               (((req_addr[31:16] ^ cs_base_r[gi]) & ~cs_mask_r[gi]) == 16'h0000); // RL3
         end
      end
   endgenerate

   always_comb
   begin
      hit_idx = 3'd0;
      for (int i = `LBI_NUM_CS - 1; i >= 0; i--)
         if (match[i])
            hit_idx = 3'(i);
   end

   assign hit         = |match;
   assign req_bytes   = size_bytes(req_size);
   assign req_pb      = {2'b00, port_bytes(cs_psize_r[hit_idx])};
   assign req_aligned = (req_size == `LBI_TSZ_BYTE) ||
                        (req_size == `LBI_TSZ_WORD ? ~req_addr[0] :
                         req_size == `LBI_TSZ_LONG ? req_addr[1:0] == 2'b00
                                                   : req_addr[3:0] == 4'h0);

   // Piece size: limited by alignment, bytes left and port width
   assign pb  = port_bytes(cs_psize_r[sel_r]);                          // RL2 RL11
   assign off = (pb == 3'd4) ? cur_r[1:0] : (pb == 3'd2) ? {1'b0, cur_r[0]} : 2'b00;
   always_comb
   begin
      n_nxt = cur_r[0] ? 3'd1 : cur_r[1] ? 3'd2 : 3'd4;                 // RL12
      if ({2'b00, n_nxt} > rem_r)
         n_nxt = (rem_r[1] ? 3'd2 : 3'd1);
      if (n_nxt > pb)
         n_nxt = pb;
   end

   // Size code shown for the access
   always_comb
   begin
      if (burst_r)
         tsiz_nxt = size_r;                                             // RL13
      else if (aligned_r && first_r)
         tsiz_nxt = size_r;                                             // RL14
      else if (n_nxt == 3'd1)
         tsiz_nxt = `LBI_TSZ_BYTE;                                      // RL10 RL12
      else if (n_nxt == 3'd2)
         tsiz_nxt = `LBI_TSZ_WORD;
      else
         tsiz_nxt = `LBI_TSZ_LONG;
   end

   // Lane strobes and write data; lane 3 is bits 31:24
   always_comb
   begin
      int k;
      k         = 0;
      lanes_nxt = 4'h0;
      wlane_nxt = 32'h0000_0000;
      for (int j = 0; j < 4; j++)
      begin
         k = 3 - j - int'(off);
         if (k >= 0 && k < int'(n_r))
         begin
            lanes_nxt[j]         = 1'b1;                                // RL16
            wlane_nxt[8*j +: 8]  = wbuf_r[127 - 8*(int'(cnt_r) + k) -: 8];
         end
      end
   end

   // Termination: internal count or synchronised external acknowledge
   // External ack ignored for two clocks so a stale synced ack is not reused
   assign ack = cs_aa_r[sel_r] ? (wait_r == cs_wait_r[sel_r])           // RL21 RL22
                               : ~ack_s2_r && wait_r > 6'd1;            // RL20

   // Select settings, boot strap capture
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         for (int i = 0; i < `LBI_NUM_CS; i++)
         begin
            cs_base_r[i]  <= 16'h0000;                                  // RL5
            cs_mask_r[i]  <= 16'h0000;
            cs_psize_r[i] <= `LBI_PS_32;
            cs_wait_r[i]  <= `LBI_BOOT_WAIT;
         end
         cs_valid_r <= 6'h01;
         cs_burst_r <= 6'h00;
         cs_aa_r    <= 6'h01;
         cs_rdl_r   <= 6'h00;
         global_r   <= 1'b1;
      end
      else if (cfg_we && cfg_idx < 3'd6)
      begin
         cs_base_r[cfg_idx]  <= cfg_base;                               // RL4
         cs_mask_r[cfg_idx]  <= cfg_mask;
         cs_psize_r[cfg_idx] <= cfg_psize;
         cs_wait_r[cfg_idx]  <= cfg_wait;
         cs_valid_r[cfg_idx] <= cfg_valid;
         cs_burst_r[cfg_idx] <= cfg_burst;
         cs_aa_r[cfg_idx]    <= cfg_auto_ack;
         cs_rdl_r[cfg_idx]   <= cfg_read_lanes;                         // RL15
         if (cfg_idx == 3'd0)
            global_r <= 1'b0;
      end
      else if (rst_s2_r && !rst_s3_r)
      begin
         cs_psize_r[0] <= ad_s2_r[1:0];                                 // RL6
         cs_aa_r[0]    <= ad_s2_r[`LBI_STRAP_AA];
      end
   end

   // Transfer sequencer
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         st_r      <= LBI_IDLE;
         cur_r     <= 32'h0000_0000;
         rem_r     <= 5'd0;
         cnt_r     <= 5'd0;
         size_r    <= `LBI_TSZ_LONG;
         read_r    <= 1'b1;
         burst_r   <= 1'b0;
         first_r   <= 1'b0;
         aligned_r <= 1'b0;
         sel_r     <= 3'd0;
         n_r       <= 3'd1;
         wait_r    <= 6'd0;
         wbuf_r    <= '0;
         rbuf_r    <= '0;
         req_ready <= 1'b1;
         done      <= 1'b0;
         no_match  <= 1'b0;
         rdata     <= '0;
      end
      else
      begin
         done     <= 1'b0;
         no_match <= 1'b0;
         unique case (st_r)
            LBI_IDLE:
               if (req_valid && req_ready)
               begin
                  if (!hit)
                     no_match <= 1'b1;
                  else
                  begin
                     st_r      <= LBI_ADDR;
                     req_ready <= 1'b0;
                     cur_r     <= req_addr;
                     rem_r     <= req_bytes;
                     cnt_r     <= 5'd0;
                     size_r    <= req_size;
                     read_r    <= req_read;
                     sel_r     <= hit_idx;
                     first_r   <= 1'b1;
                     aligned_r <= req_aligned;
                     burst_r   <= req_burst_ok && cs_burst_r[hit_idx] &&
                                  req_aligned && req_bytes > req_pb;    // RL9
                     wbuf_r    <= req_wdata;
                  end
               end
            LBI_ADDR:
            begin
               st_r   <= LBI_DATA;
               n_r    <= n_nxt;
               wait_r <= 6'd0;
            end
            LBI_DATA:
               if (!ack)
                  wait_r <= wait_r + 6'd1;
               else
               begin
                  for (int j = 0; j < 4; j++)
                     if (read_r && lanes_nxt[j])
                        rbuf_r[127 - 8*(int'(cnt_r) + 3 - j - int'(off)) -: 8]
                           <= ad_s2_r[8*j +: 8];
                  cnt_r   <= cnt_r + {2'b00, n_r};
                  rem_r   <= rem_r - {2'b00, n_r};
                  cur_r   <= cur_r + {29'h0, n_r};
                  first_r <= 1'b0;
                  wait_r  <= 6'd0;
                  if (!(burst_r && rem_r != {2'b00, n_r}))
                     st_r <= LBI_HOLD;
               end
            LBI_HOLD:
               if (rem_r != 5'd0)
                  st_r <= LBI_ADDR;
               else
               begin
                  st_r      <= LBI_IDLE;
                  req_ready <= 1'b1;
                  done      <= 1'b1;
                  rdata     <= rbuf_r;
               end
         endcase
      end
   end

   // Registered pin outputs, one clock behind the sequencer state
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         ad_out        <= 32'h0000_0000;
         ad_oe_n       <= 1'b1;
         chip_select_n <= `LBI_CS_OFF;
         cycle_begin_n <= 1'b1;
         read_write    <= 1'b1;
         burst_flag_n  <= 1'b1;
         transfer_size <= `LBI_TSZ_LONG;
         lane_select_n <= `LBI_LANES_OFF;
         output_en_n   <= 1'b1;
      end
      else
      begin
         ad_out        <= (st_r == LBI_ADDR) ? cur_r :                  // RL1
                          (st_r == LBI_DATA) ? wlane_nxt : ad_out;      // RL18
         ad_oe_n       <= !(st_r == LBI_ADDR ||
                            (!read_r && (st_r == LBI_DATA ||
                                         st_r == LBI_HOLD)));           // RL18
         chip_select_n <= (st_r == LBI_DATA) ? ~(6'h01 << sel_r)
                                             : `LBI_CS_OFF;             // RL3
         cycle_begin_n <= !(st_r == LBI_ADDR);                          // RL7
         read_write    <= (st_r == LBI_IDLE) ? 1'b1 : read_r;           // RL8
         burst_flag_n  <= !(burst_r && st_r != LBI_IDLE);               // RL9
         if (st_r == LBI_ADDR)
            transfer_size <= tsiz_nxt;                                  // RL14
         lane_select_n <= (st_r == LBI_DATA && (!read_r || cs_rdl_r[sel_r]))
                          ? ~lanes_nxt : `LBI_LANES_OFF;                // RL15 RL16
         output_en_n   <= !(st_r == LBI_DATA && read_r);                // RL17 RL19
      end
   end

endmodule
`default_nettype wire

// file: verif/lbi_master_properties.sv
// Pin protocol checker for the local bus master, bound to lbi_master.
// Assumes one clock domain, mclk, with synchronous reset srst.
`timescale 1ns/1ps
`default_nettype none
`include "lbi_defs.svh"
module lbi_master_props
   import lbi_pkg::*;
(
   input wire logic        mclk,          // Clock
   input wire logic        srst,          // Reset
   input wire logic        req_valid,     // Request
   input wire logic        req_ready,     // Idle
   input wire logic        req_read,      // Direction asked
   input wire logic [31:0] req_addr,      // Address asked
   input wire logic        no_match,      // Request dropped
   input wire logic [31:0] ad_out,        // Bus value
   input wire logic        ad_oe_n,       // Bus drive
   input wire logic [5:0]  chip_select_n, // Selects
   input wire logic        cycle_begin_n, // Start strobe
   input wire logic        read_write,    // Direction
   input wire logic        burst_flag_n,  // Burst
   input wire logic [1:0]  transfer_size, // Size code
   input wire logic [3:0]  lane_select_n, // Byte strobes
   input wire logic        output_en_n    // Read enable
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);
   logic rd_r;
   // Direction of the request in flight
   always_ff @(posedge mclk)
   begin
      if (srst)
         rd_r <= 1'b1;
      else if (req_valid && req_ready)
         rd_r <= req_read;
   end
   sequence s_take;
      (req_valid && req_ready) ##1 !no_match;
   endsequence
   sequence s_addr;
      !cycle_begin_n && !ad_oe_n && ad_out == $past(req_addr, 2);
   endsequence
   property p_addr;
      s_take |=> s_addr;
   endproperty
   property p_dir;
      !cycle_begin_n |-> read_write == rd_r;
   endproperty
   property p_start;
      $fell(cycle_begin_n) |=> cycle_begin_n;
   endproperty
   property p_oe;
      !output_en_n |-> read_write && chip_select_n != `LBI_CS_OFF;
   endproperty
   property p_whold;
      $rose(chip_select_n == `LBI_CS_OFF) && !rd_r |->
         !ad_oe_n && $stable(ad_out);
   endproperty
   property p_onesel;
      $onehot0(~chip_select_n);
   endproperty
   property p_lanes;
      lane_select_n != `LBI_LANES_OFF |-> chip_select_n != `LBI_CS_OFF;
   endproperty
   property p_bsize;
      !burst_flag_n && !$past(burst_flag_n) |-> $stable(transfer_size);
   endproperty
   property p_align;
      !cycle_begin_n |-> (transfer_size != `LBI_TSZ_WORD || !ad_out[0])
         && (transfer_size != `LBI_TSZ_LONG || ad_out[1:0] == 2'h0)
         && (transfer_size != `LBI_TSZ_LINE || ad_out[3:0] == 4'h0);
   endproperty
   a_addr: assert property (p_addr) else $error("address phase wrong");
   a_dir: assert property (p_dir) else $error("direction wrong");
   a_start: assert property (p_start) else $error("strobe too long");
   a_oe: assert property (p_oe) else $error("output enable wrong");
   a_whold: assert property (p_whold) else $error("data hold short");
   a_onesel: assert property (p_onesel) else $error("two selects");
   a_lanes: assert property (p_lanes) else $error("stray strobes");
   a_bsize: assert property (p_bsize) else $error("size moved");
   a_align: assert property (p_align) else $error("piece misaligned");
endmodule
bind lbi_master lbi_master_props chk_u (
   .mclk, .srst, .req_valid, .req_ready, .req_read, .req_addr, .no_match,
   .ad_out, .ad_oe_n, .chip_select_n, .cycle_begin_n, .read_write,
   .burst_flag_n, .transfer_size, .lane_select_n, .output_en_n
);
`default_nettype wire

// file: verif/lbi_peripheral_model.sv
// Peripheral on the multiplexed bus: read data and external acknowledge.
// Assumes bus is the resolved wire level and everything runs on mclk.
`timescale 1ns/1ps
`default_nettype none
module lbi_peripheral_model
   import lbi_pkg::*;
(
   input  wire logic        mclk,          // Clock
   input  wire logic        srst,          // Reset
   input  wire logic [31:0] bus,           // Resolved bus lines
   input  wire logic [5:0]  chip_select_n, // Selects
   input  wire logic        cycle_begin_n, // Start strobe
   input  wire logic        output_en_n,   // Read enable
   input  wire logic        ack_en,        // Answer with acknowledge
   input  wire logic [7:0]  ack_dly,       // Clocks before acknowledge
   output logic [31:0]      per_ad,        // Value put on the lines
   output logic             cycle_ack_n    // Acknowledge
);
   logic [31:0] addr_r;
   logic [7:0]  cnt_r;
   logic [1:0]  hold_r;
   // Address latched at the start strobe
   always_ff @(posedge mclk)
   begin
      if (!cycle_begin_n)
         addr_r <= bus;
   end
   // Data held past the enable, then a toggling pattern once released
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         hold_r <= 2'h0;
         per_ad <= 32'h0000_0000;
      end
      else if (!output_en_n)
      begin
         hold_r <= 2'h3;
         per_ad <= addr_r ^ 32'h5a5a_5a5a;
      end
      else if (hold_r != 2'h0)
         hold_r <= hold_r - 2'h1;
      else
         per_ad <= ~per_ad;
   end
   // Acknowledge after the delay, held until the select ends
   always_ff @(posedge mclk)
   begin
      if (srst || chip_select_n == 6'h3f)
      begin
         cnt_r <= 8'h00;
         cycle_ack_n <= 1'b1;
      end
      else if (cnt_r == ack_dly)
         cycle_ack_n <= !ack_en;
      else
         cnt_r <= cnt_r + 8'h01;
   end
endmodule
`default_nettype wire

// file: verif/local_bus_interface_tb_top.sv
// Random and corner-case bench for the local bus master.
// Assumes the checker and peripheral model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "lbi_defs.svh"
module local_bus_interface_tb_top
   import lbi_pkg::*;
;
   logic         mclk, srst, cfg_we, cfg_valid, cfg_burst, cfg_auto_ack;
   logic         cfg_read_lanes, req_valid, req_read, req_burst_ok;
   logic         req_ready, done, no_match, ad_oe_n, cycle_begin_n;
   logic         read_write, burst_flag_n, output_en_n, cycle_ack_n;
   logic         reset_in_n, ack_en, strap_en, bexp;
   logic [1:0]   cfg_psize, req_size, transfer_size, sz_q[$], exp_q[$];
   logic [2:0]   cfg_idx, strap;
   logic [3:0]   lane_select_n, ln_seen, lexp;
   logic [5:0]   cfg_wait, chip_select_n, cs_seen;
   logic [7:0]   ack_dly;
   logic [15:0]  cfg_base, cfg_mask;
   logic [31:0]  req_addr, ad_in, ad_out, per_ad, a, r;
   logic [127:0] req_wdata, rdata;
   logic         bf_q[$];
   integer       seed, fails, n_compared, n, cyc, i, j, w, pb;
   int           nbt[4] = '{4, 1, 2, 16};
   int           pbt[4] = '{4, 1, 2, 2};
   lbi_master dut_u (.mclk, .srst, .cfg_we, .cfg_idx, .cfg_valid, .cfg_base,
      .cfg_mask, .cfg_psize, .cfg_burst, .cfg_wait, .cfg_auto_ack,
      .cfg_read_lanes, .req_valid, .req_ready, .req_read, .req_size,
      .req_burst_ok, .req_addr, .req_wdata, .done, .no_match, .rdata, .ad_in,
      .ad_out, .ad_oe_n, .chip_select_n, .cycle_begin_n, .read_write,
      .burst_flag_n, .transfer_size, .lane_select_n, .output_en_n,
      .cycle_ack_n, .reset_in_n);
   lbi_peripheral_model per_u (.mclk, .srst, .bus(ad_in), .chip_select_n,
      .cycle_begin_n, .output_en_n, .ack_en, .ack_dly, .per_ad, .cycle_ack_n);
   // Wire level: master, board straps at reset rise, or the peripheral
   assign ad_in = !ad_oe_n ? ad_out : (strap_en ? {29'h0, strap} : per_ad);
   initial mclk = 1'b0;
   always #12.5 mclk = ~mclk;
   // Watchdog, and records of sizes, burst flag, selects and strobes
   always @(posedge mclk)
   begin
      cyc = cyc + 1;
      if (cyc > 60000)
      begin
         fails = fails + 1;
         results();
      end
      if (!cycle_begin_n)
      begin
         sz_q.push_back(transfer_size);
         bf_q.push_back(burst_flag_n);
      end
      if (chip_select_n != `LBI_CS_OFF)
      begin
         cs_seen = chip_select_n;
         ln_seen = ln_seen & lane_select_n;
      end
   end
   task automatic check(input logic [127:0] got, input logic [127:0] exp);
   begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
         fails = fails + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task automatic results();
   begin
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
   endtask
   task automatic cfg(input logic [2:0] idx, input logic [15:0] base,
      input logic [15:0] mk, input logic [1:0] ps, input logic bu,
      input logic [5:0] wt, input logic rl);
   begin
      @(negedge mclk);
      {cfg_we, cfg_idx, cfg_valid, cfg_base, cfg_mask} = {1'b1, idx, 1'b1,
         base, mk};
      {cfg_psize, cfg_burst, cfg_wait, cfg_auto_ack} = {ps, bu, wt, 1'b1};
      cfg_read_lanes = rl;
      @(negedge mclk);
      cfg_we = 1'b0;
   end
   endtask
   task automatic xfer(input logic rd, input logic [1:0] sz, input logic bo,
      input logic [31:0] ad);
   begin
      sz_q.delete();
      bf_q.delete();
      cs_seen = `LBI_CS_OFF;
      ln_seen = `LBI_LANES_OFF;
      @(negedge mclk);
      {req_valid, req_read, req_size, req_burst_ok, req_addr} = {1'b1, rd,
         sz, bo, ad};
      req_wdata = {$random(seed), $random(seed), $random(seed), a};
      @(negedge mclk);
      req_valid = 1'b0;
      n = 0;
      while (done !== 1'b1 && no_match !== 1'b1 && n < 3000)
      begin
         @(negedge mclk);
         n = n + 1;
      end
      if (n >= 3000)
      begin
         fails = fails + 1;
         results();
      end
   end
   endtask
   function automatic logic [1:0] code(input int b);
      return b == 1 ? `LBI_TSZ_BYTE : b == 2 ? `LBI_TSZ_WORD :
         b == 16 ? `LBI_TSZ_LINE : `LBI_TSZ_LONG;
   endfunction
   // Pieces: largest aligned power of two within bytes left and port
   task automatic expect_sizes(input logic [31:0] ad, input int nb,
      input int p_b, input logic bo);
      int  p;
      int  left;
      logic al;
   begin
      al = (ad % nb == 0);
      bexp = al && bo && nb > p_b;
      exp_q.delete();
      left = nb;
      while (left > 0)
      begin
         p = p_b;
         while (p > left || ad % p != 0)
            p = p / 2;
         exp_q.push_back(code(p));
         ad = ad + p;
         left = left - p;
      end
      if (al)
         exp_q[0] = code(nb);
      if (bexp)
         exp_q = {code(nb)};
   end
   endtask
   initial
   begin
      {seed, fails, n_compared, cyc} = {32'd1, 96'd0};
      {srst, cfg_we, cfg_valid, cfg_burst, cfg_auto_ack} = 5'h10;
      {cfg_read_lanes, req_valid, req_read, req_burst_ok} = 4'h0;
      {cfg_idx, cfg_psize, req_size, cfg_wait, cfg_base, cfg_mask} = 45'h0;
      {req_addr, req_wdata, a} = 192'h0;
      {reset_in_n, ack_en, strap_en, strap, ack_dly} = 14'h2000;
      repeat (3) @(negedge mclk);
      srst = 1'b0;
      check(chip_select_n, `LBI_CS_OFF);
      check(req_ready, 1'b1);
      // Global boot select answers anywhere after its default wait
      a = $random(seed) & 32'hffff_fffc;
      xfer(1'b1, `LBI_TSZ_LONG, 1'b0, a);
      check(cs_seen, 6'h3e);
      check(n, `LBI_BOOT_WAIT + 3);
      check(rdata[127:96], a ^ 32'h5a5a_5a5a);
      // Boot select strapped to external end; the peripheral sets waits
      strap_en = 1'b1;
      reset_in_n = 1'b0;
      repeat (4) @(negedge mclk);
      reset_in_n = 1'b1;
      repeat (6) @(negedge mclk);
      {strap_en, ack_en, ack_dly} = 10'h10c;
      xfer(1'b1, `LBI_TSZ_LONG, 1'b0, a);
      check(n > 16 && n < 40, 1'b1);
      check(rdata[127:96], a ^ 32'h5a5a_5a5a);
      ack_en = 1'b0;
      // Two regions, every port width, random sizes, offsets, directions
      cfg(3'h0, 16'h0000, 16'h0000, 2'h0, 1'b0, 6'h00, 1'b1);
      for (i = 0; i < 12; i++)
      begin
         pb = i % 3;
         w = $random(seed) & 3;
         cfg(3'h1, 16'h8a00, 16'h00ff, pb[1:0], i[1], w[5:0], i[2]);
         for (j = 0; j < 8; j++)
         begin
            a = $random(seed);
            a[31:24] = 8'h8a;
            r = $random(seed);
            xfer(r[0], r[2:1], r[3], a);
            expect_sizes(a, nbt[r[2:1]], pbt[pb], r[3] && i[1]);
            check(sz_q.size(), exp_q.size());
            foreach (exp_q[k])
               check(sz_q[k], exp_q[k]);
            foreach (bf_q[k])
               check(bf_q[k], !bexp);
            check(cs_seen, 6'h3d);
            lexp = ~(4'h1 << (3 - a % pbt[pb]));
            if (r[0] && !i[2])
               lexp = `LBI_LANES_OFF;
            if (r[2:1] == `LBI_TSZ_BYTE)
               check(ln_seen, lexp);
            if (exp_q.size() == 1 && nbt[r[2:1]] <= pbt[pb])
               check(n, w + 3);
         end
      end
      // Address outside every region is dropped with no select
      xfer(1'b1, `LBI_TSZ_LONG, 1'b0, 32'h4000_0000);
      check(no_match, 1'b1);
      check(cs_seen, `LBI_CS_OFF);
      results();
   end
endmodule
`default_nettype wire
